// ### design/ext_irq_defs.svh
/*
  Register indices, field positions, reset values and vector
  addresses of the external pin interrupt unit.
  Assumes inclusion by bare name from the design files that use it.
*/
`ifndef EXT_IRQ_DEFS_SVH
`define EXT_IRQ_DEFS_SVH

// Register indices, byte address is four times the index
`define IDX_MASK_LOW 6'h12
`define IDX_MASK_HIGH 6'h20
`define IDX_FLAGS 6'h3A
`define IDX_ENABLES 6'h3B
`define IDX_SENSE 6'h35

// Field positions in enables and flags
`define BIT_DED 6
`define BIT_GRP_HIGH 5
`define BIT_GRP_LOW 4

// Reset value of every register
`define RST_REG 8'h00

// Program word of each vector
`define VEC_NONE 16'h0000
`define VEC_DED 16'h0001
`define VEC_GRP_LOW 16'h0002
`define VEC_GRP_HIGH 16'h0003

// Synchroniser depth for pin inputs
`define SYNC_STAGES 3

`endif

// ### design/irq_pkg.sv
/*
  Types shared by the external pin interrupt unit.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package irq_pkg;
  // Sense control codes of the dedicated pin
  typedef enum logic [1:0] {
    SENSE_LOW = 2'h0,
    SENSE_ANY = 2'h1,
    SENSE_FALL = 2'h2,
    SENSE_RISE = 2'h3
  } sense_e;
endpackage

// ### design/pin_sync.sv
/*
  Three-stage pin synchroniser with agreement filter.
  Assumes asynchronous pins and a clock enable that freezes it.
*/
`timescale 1ns/10ps
`include "ext_irq_defs.svh"
module pin_sync #(
  parameter int W = 13
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] stable
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  ////////////////////////////////////////////////////////////////
  // One chain per pin, value taken when stages two and three agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          s1_q[i] <= 1'b0;
          s2_q[i] <= 1'b0;
          s3_q[i] <= 1'b0;
          stable[i] <= 1'b0;
        end else if (ce) begin
          s1_q[i] <= async_in[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          if (s2_q[i] == s3_q[i]) begin
            stable[i] <= s3_q[i];
          end
        end
      end
    end
  endgenerate
endmodule

// ### design/sense_decode.sv
/*
  Sense decoder of the dedicated interrupt pin.
  Assumes cur and prev are consecutive synchronised samples.
*/
`timescale 1ns/10ps
module sense_decode (
  input irq_pkg::sense_e mode,
  input wire logic cur,
  input wire logic prev,
  output logic trig,
  output logic level
);
  import irq_pkg::*;

  // Edge and change events, low level kept apart
  assign trig = (mode == SENSE_ANY && cur != prev) ||
                (mode == SENSE_FALL && prev && !cur) ||
                (mode == SENSE_RISE && !prev && cur);
  assign level = (mode == SENSE_LOW) && !cur;
endmodule

// ### design/ext_irq_unit.sv
/*
  External pin interrupt unit: one dedicated pin with selectable
  sense and twelve pin-change inputs in two groups, registers on a
  classic Wishbone slave, vector request towards the core.
  Assumes pins arrive unsynchronised, the core supplies its global
  interrupt bit and pulses irq_taken when it enters the vector
  shown on irq_vector; ce low stands for a stopped I/O clock.
*/
`timescale 1ns/10ps
`include "ext_irq_defs.svh"
module ext_irq_unit #(
  parameter int CHG_W = 12,
  parameter int LOW_W = 8
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic dedicated_irq_pin,
  input wire logic [CHG_W-1:0] change_inputs_all,
  input wire logic global_irq_en,
  input wire logic irq_taken,
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic wake
);
  import irq_pkg::*;

  localparam int HIGH_W = CHG_W - LOW_W;

  // Register state
  logic [LOW_W-1:0] mask_low_q;
  logic [HIGH_W-1:0] mask_high_q;
  logic [2:0] en_q;
  logic [2:0] en_d;
  logic [2:0] flag_q;
  logic [2:0] flag_d;
  sense_e sense_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic req_q;
  logic [15:0] vec_q;
  logic [CHG_W:0] stab;
  logic [CHG_W:0] prev_q;

  ////////////////////////////////////////////////////////////////
  // Bus decode

  // Index match, used for reads and writes alike
  function automatic logic reg_hit(input logic [5:0] a, input logic [5:0] b);
    reg_hit = (a == b);
  endfunction

  wire bus_req = wb_cyc_i & wb_stb_i;
  wire access = bus_req & ~ack_q;
  // Write commits at the edge where the master samples ack high
  wire wr_en = bus_req & ack_q & wb_we_i & wb_sel_i[0];
  wire [5:0] idx = wb_adr_i[7:2];
  wire [7:0] wdat = wb_dat_i[7:0];
  wire sel_mlow = reg_hit(idx, `IDX_MASK_LOW);
  wire sel_mhigh = reg_hit(idx, `IDX_MASK_HIGH);
  wire sel_flags = reg_hit(idx, `IDX_FLAGS);
  wire sel_en = reg_hit(idx, `IDX_ENABLES);
  wire sel_sense = reg_hit(idx, `IDX_SENSE);

  // Read views, reserved positions tied low
  wire [7:0] flags_view = {1'b0, flag_q, 4'h0};
  wire [7:0] en_view = {1'b0, en_q, 4'h0};
  wire [7:0] mhigh_view = {{(8-HIGH_W){1'b0}}, mask_high_q};
  wire [7:0] sense_view = {6'h00, sense_q};
  wire [7:0] rd_byte = sel_mlow ? mask_low_q :
                       sel_mhigh ? mhigh_view :
                       sel_flags ? flags_view :
                       sel_en ? en_view :
                       sel_sense ? sense_view : 8'h00;

  ////////////////////////////////////////////////////////////////
  // Wishbone answer: one-cycle ack, unmapped reads give zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else if (ce) begin
      ack_q <= access;
      if (access) begin
        dat_q <= {24'h000000, rd_byte};
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  ////////////////////////////////////////////////////////////////
  // Control registers written by software
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_low_q <= `RST_REG;
      mask_high_q <= '0;
      en_q <= 3'h0;
      sense_q <= SENSE_LOW;
    end else if (ce) begin
      if (wr_en && sel_mlow) begin
        mask_low_q <= wdat[LOW_W-1:0];
      end
      if (wr_en && sel_mhigh) begin
        mask_high_q <= wdat[HIGH_W-1:0];
      end
      if (wr_en && sel_en) begin
        en_q <= en_d;
      end
      if (wr_en && sel_sense) begin
        sense_q <= sense_e'(wdat[1:0]);
      end
    end
  end

  // Enable fields: dedicated, group high, group low
  assign en_d = {wdat[`BIT_DED], wdat[`BIT_GRP_HIGH], wdat[`BIT_GRP_LOW]};

  ////////////////////////////////////////////////////////////////
  // Pin sampling; pads are read whatever their direction
  pin_sync #(
    .W(CHG_W + 1)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .async_in({dedicated_irq_pin, change_inputs_all}),
    .stable(stab)
  );

  // Previous sample, frozen while the I/O clock is stopped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_q <= '0;
    end else if (ce) begin
      prev_q <= stab;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Dedicated pin sense
  wire ded_trig;
  wire ded_level;

  sense_decode u_sense (
    .mode(sense_q),
    .cur(stab[CHG_W]),
    .prev(prev_q[CHG_W]),
    .trig(ded_trig),
    .level(ded_level)
  );

  ////////////////////////////////////////////////////////////////
  // Pin-change groups
  wire [CHG_W-1:0] chg_mask = {mask_high_q, mask_low_q};
  wire [CHG_W-1:0] stab_chg = stab[CHG_W-1:0];
  wire [CHG_W-1:0] prev_chg = prev_q[CHG_W-1:0];
  wire [CHG_W-1:0] chg_diff = (stab_chg ^ prev_chg) & chg_mask;
  wire hit_low = en_q[0] & (|chg_diff[LOW_W-1:0]);
  wire hit_high = en_q[1] & (|chg_diff[CHG_W-1:LOW_W]);

  // Asynchronous wake: raw change pins against last stable value, raw dedicated pin low in level mode
  wire [CHG_W-1:0] raw_diff = (change_inputs_all ^ stab_chg) & chg_mask;
  wire wake_chg = (en_q[0] & (|raw_diff[LOW_W-1:0])) |
                  (en_q[1] & (|raw_diff[CHG_W-1:LOW_W]));
  wire wake_lvl = en_q[2] & (sense_q == SENSE_LOW) & ~dedicated_irq_pin;
  assign wake = wake_chg | wake_lvl;

  ////////////////////////////////////////////////////////////////
  // Flag clearing by vector entry and by writing one
  wire sw_clr = wr_en & sel_flags;
  wire take = irq_taken & req_q;
  wire clr_ded = (sw_clr & wdat[`BIT_DED]) | (take & (vec_q == `VEC_DED));
  wire clr_low = (sw_clr & wdat[`BIT_GRP_LOW]) | (take & (vec_q == `VEC_GRP_LOW));
  wire clr_high = (sw_clr & wdat[`BIT_GRP_HIGH]) | (take & (vec_q == `VEC_GRP_HIGH));
  wire lvl_mode = (sense_q == SENSE_LOW);

  // Next flags, a new event wins over a clear
  assign flag_d[2] = lvl_mode ? 1'b0 : (ded_trig | (flag_q[2] & ~clr_ded));
  assign flag_d[1] = hit_high | (flag_q[1] & ~clr_high);
  assign flag_d[0] = hit_low | (flag_q[0] & ~clr_low);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_q <= 3'h0;
    end else if (ce) begin
      flag_q <= flag_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Vector request, lowest vector first; level held only while low
  wire pend_ded = en_q[2] & (lvl_mode ? ded_level : flag_d[2]);
  wire pend_low = en_q[0] & flag_d[0];
  wire pend_high = en_q[1] & flag_d[1];
  wire req_d = global_irq_en & (pend_ded | pend_low | pend_high);
  wire [15:0] vec_d = !req_d ? `VEC_NONE :
                      pend_ded ? `VEC_DED :
                      pend_low ? `VEC_GRP_LOW : `VEC_GRP_HIGH;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_q <= 1'b0;
      vec_q <= `VEC_NONE;
    end else if (ce) begin
      req_q <= req_d;
      vec_q <= vec_d;
    end
  end

  assign irq_req = req_q;
  assign irq_vector = vec_q;

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Ack lasts exactly one cycle
  ack_single_cycle_a: assert property (ce && wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // Edge event sets the dedicated flag
  ded_flag_set_a: assert property (ce && ded_trig && !lvl_mode |=> flags_view[6])
    else $error("dedicated flag not set by edge");

  // Level mode keeps the dedicated flag clear
  level_flag_clear_a: assert property (ce && lvl_mode |=> !flag_q[2])
    else $error("dedicated flag set in level mode");

  // Steady low level keeps requesting the dedicated vector
  level_request_a: assert property (
    ce && lvl_mode && en_q[2] && !stab[CHG_W] && global_irq_en
    |=> irq_req && irq_vector == 16'h0001)
    else $error("low level not requested");

  // Enabled low-group toggle sets its flag
  group_low_set_a: assert property (ce && hit_low |=> flags_view[4])
    else $error("low group flag not set");

  // With every pin masked, neither group hits
  mask_gate_a: assert property (chg_mask == 12'h000 |-> !hit_low && !hit_high)
    else $error("masked pin reached a group");

  // No request without the global bit
  global_gate_a: assert property (ce && !global_irq_en |=> !irq_req)
    else $error("request without global enable");

  // Read data above the byte is zero while ack is high
  reserved_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("reserved read bits not zero");

  // Group high vector only when nothing higher pends
  vector_order_a: assert property (
    irq_req && irq_vector == 16'h0003 |-> $past(!pend_ded && !pend_low) || !$past(ce))
    else $error("vector priority broken");

  // Low level with enable drives the wake output
  wake_level_a: assert property (
    en_q[2] && lvl_mode && !dedicated_irq_pin |-> wake)
    else $error("low level did not wake");

  // Every taken request is answered on the next edge
  ack_after_take_a: assert property (
    ce && access |=> wb_ack_o)
    else $error("request not acknowledged");

  // Enabled high-group toggle sets its flag
  group_high_set_a: assert property (
    ce && hit_high |=> flags_view[5])
    else $error("high group flag not set");

  // Vector entry clears the low group flag
  low_take_clear_a: assert property (
    ce && take && vec_q == 16'h0002 && !hit_low |=> !flag_q[0])
    else $error("low group flag not cleared on entry");

  // Vector entry clears the high group flag
  high_take_clear_a: assert property (
    ce && take && vec_q == 16'h0003 && !hit_high |=> !flag_q[1])
    else $error("high group flag not cleared on entry");

  // Writing one clears the dedicated flag
  ded_write_clear_a: assert property (
    ce && sw_clr && wdat[6] && !ded_trig |=> !flag_q[2])
    else $error("dedicated flag not cleared by write");

  // Writing one clears the low group flag
  low_write_clear_a: assert property (
    ce && sw_clr && wdat[4] && !hit_low |=> !flag_q[0])
    else $error("low group flag not cleared by write");

  // No request means no vector shown
  idle_vector_zero_a: assert property (
    !irq_req |-> irq_vector == 16'h0000)
    else $error("vector shown without request");

  // Stopped I/O clock freezes flags and vector
  freeze_hold_a: assert property (
    !ce |=> $stable(flag_q) && $stable(irq_vector))
    else $error("state moved while clock stopped");

  // Disabled high group never raises its flag
  group_enable_gate_a: assert property (
    ce && !en_q[1] && !flag_q[1] |=> !flag_q[1])
    else $error("disabled group flag set");

  // High pin in level mode ends the dedicated request
  level_release_a: assert property (
    ce && lvl_mode && stab[CHG_W] && !pend_low && !pend_high |=> !irq_req)
    else $error("level request held after release");

  // Group low vector only when the dedicated pin does not pend
  low_vector_order_a: assert property (
    irq_req && irq_vector == 16'h0002 |-> $past(!pend_ded) || !$past(ce))
    else $error("low group vector ahead of dedicated");

  // Dedicated enable cleared, no request from that pin
  ded_enable_gate_a: assert property (
    ce && !en_q[2] && !pend_low && !pend_high |=> !irq_req)
    else $error("request with dedicated enable clear");
endmodule

// ### testbench/pin_model.sv
/*
  Model of the outside party on the interrupt pins.
  Assumes the bench sets wanted levels just after a clock edge.
*/
`timescale 1ns/10ps
module pin_model (
  input wire logic ded_lvl,
  input wire logic [11:0] chg_lvl,
  output logic dedicated_irq_pin,
  output logic [11:0] change_inputs_all
);
  // Pins follow the wanted levels, held for many clock periods
  assign dedicated_irq_pin = ded_lvl;
  assign change_inputs_all = chg_lvl;
endmodule

// ### testbench/ext_irq_unit_tb.sv
/*
  Self-checking bench of the external pin interrupt unit.
  Assumes the unit, its defines header and the pin model.
*/
`timescale 1ns/10ps
`include "ext_irq_defs.svh"
module ext_irq_unit_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic glob = 1'b0;
  logic taken = 1'b0;
  logic ded = 1'b1;
  logic [11:0] chg = 12'h000;
  logic ded_pin, irq_req, ack, wake;
  logic [11:0] chg_pin;
  logic [31:0] rdat;
  logic [15:0] vec;
  int n_fail = 0;
  int compares = 0;
  logic e;

  ////////////////////////////////////////////////////////////////
  // Clock and instances
  always #4 clk = ~clk;

  ext_irq_unit i_ext_irq_unit (.clk(clk), .rst(rst), .ce(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .dedicated_irq_pin(ded_pin),
    .change_inputs_all(chg_pin), .global_irq_en(glob), .irq_taken(taken),
    .irq_req(irq_req), .irq_vector(vec), .wake(wake));

  pin_model i_pin_model (.ded_lvl(ded), .chg_lvl(chg), .dedicated_irq_pin(ded_pin),
    .change_inputs_all(chg_pin));

  ////////////////////////////////////////////////////////////////
  // Tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, g, x);
    end
  endtask

  task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d,
                     output logic [31:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    dat <= {24'h0, d};
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, i, d, r);
  endtask

  task automatic rd(input logic [5:0] i, input logic [7:0] x);
    logic [31:0] r;
    bus(1'b0, i, 8'h00, r);
    chk(r, {24'h0, x});
  endtask

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic test_done;
    if (n_fail == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    cyc_wait(3000);
    n_fail++;
    test_done;
  end

  ////////////////////////////////////////////////////////////////
  // Tests
  initial begin
    cyc_wait(3);
    rst <= 1'b0;
    @(posedge clk);
    rd(`IDX_MASK_LOW, 8'h00);
    rd(`IDX_FLAGS, 8'h00);
    rd(6'h10, 8'h00);
    wr(`IDX_MASK_HIGH, 8'hFF);
    rd(`IDX_MASK_HIGH, 8'h0F);
    wr(`IDX_ENABLES, 8'hFF);
    rd(`IDX_ENABLES, 8'h70);
    wr(`IDX_MASK_LOW, 8'h01);
    wr(`IDX_MASK_HIGH, 8'h08);
    wr(`IDX_ENABLES, 8'h30);
    glob <= 1'b1;
    // Masked pin toggles, then an unmasked one
    chg <= 12'h002;
    cyc_wait(8);
    chk(irq_req, 0);
    chg <= 12'h003;
    cyc_wait(8);
    chk(vec, `VEC_GRP_LOW);
    rd(`IDX_FLAGS, 8'h10);
    taken <= 1'b1;
    @(posedge clk);
    taken <= 1'b0;
    @(posedge clk);
    chk(irq_req, 0);
    chg <= 12'h803;
    cyc_wait(8);
    chk(vec, `VEC_GRP_HIGH);
    glob <= 1'b0;
    cyc_wait(2);
    chk(irq_req, 0);
    wr(`IDX_FLAGS, 8'h20);
    rd(`IDX_FLAGS, 8'h00);
    glob <= 1'b1;
    // Dedicated pin, each edge mode, both directions
    wr(`IDX_ENABLES, 8'h40);
    for (int m = 1; m < 4; m++) begin
      wr(`IDX_SENSE, m[7:0]);
      for (int k = 0; k < 2; k++) begin
        wr(`IDX_FLAGS, 8'h70);
        ded <= ~ded;
        cyc_wait(8);
        e = (m == 1) || (m == 2 && !ded) || (m == 3 && ded);
        chk(irq_req, e);
        if (e) chk(vec, `VEC_DED);
        rd(`IDX_FLAGS, {1'b0, e, 6'h0});
      end
    end
    // Low level keeps requesting, flag stays clear
    wr(`IDX_FLAGS, 8'h70);
    wr(`IDX_SENSE, 8'h00);
    ded <= 1'b0;
    cyc_wait(30);
    chk(irq_req, 1);
    chk(vec, `VEC_DED);
    rd(`IDX_FLAGS, 8'h00);
    ded <= 1'b1;
    cyc_wait(8);
    chk(irq_req, 0);
    // Stopped clock: change pin wakes, edges lost
    wr(`IDX_SENSE, 8'h03);
    wr(`IDX_ENABLES, 8'h50);
    ce <= 1'b0;
    chg <= 12'h802;
    cyc_wait(2);
    chk(wake, 1);
    ded <= 1'b0;
    cyc_wait(4);
    ded <= 1'b1;
    cyc_wait(4);
    ce <= 1'b1;
    cyc_wait(8);
    rd(`IDX_FLAGS, 8'h10);
    test_done;
  end
endmodule
